// ===== hdl/cfg_pkg.sv
package cfg_pkg;

   // Clock rate and start-up time on the internal oscillator
   localparam int unsigned CLK_MHZ     = 100;
   localparam int unsigned STARTUP_NS  = 1000;
   localparam int unsigned STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W       = 16;

   // Register byte offsets
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_CM_DIV  = 8'h04;
   localparam logic [7:0]  OFS_CH_PD   = 8'h08;
   localparam logic [7:0]  OFS_STATUS  = 8'h0c;
   localparam logic [7:0]  OFS_CODE    = 8'h10;

   // Field widths and positions
   localparam int unsigned CTRL_W      = 6;
   localparam int unsigned CM_DIV_W    = 5;
   localparam int unsigned CH_N        = 4;
   localparam int unsigned ST_SPI_POS  = 0;
   localparam int unsigned ST_XTAL_POS = 1;
   localparam int unsigned ST_EXT_POS  = 2;
   localparam int unsigned ST_CORR_POS = 3;
   localparam int unsigned ST_QTR_POS  = 4;

   // Reset values and limits
   localparam logic [CM_DIV_W-1:0] CM_DIV_HALF = 5'h0a;
   localparam logic [CM_DIV_W-1:0] CM_DIV_MIN  = 5'h01;
   localparam logic [CM_DIV_W-1:0] CM_DIV_MAX  = 5'h13;
   localparam logic [CH_N-1:0]     CH_PD_RST   = 4'h0;

   // Output code format
   localparam int unsigned CODE_W   = 24;
   localparam logic [23:0] CODE_MAX = 24'h7fffff;
   localparam logic [23:0] CODE_MIN = 24'h800000;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_STRAP = 2'b00,
      ST_OSC   = 2'b01,
      ST_RUN   = 2'b10
   } boot_state_t;

   // Control word, bit 0 first from the right
   typedef struct packed {
      logic soft_reset;
      logic sleep_en;
      logic cm_src_sel;
      logic cm_buf_pwrdn;
      logic clk_out_en;
      logic ref_corr_en;
   } ctrl_t;

   // Common-mode output drive: level in twentieths of the reference
   typedef struct packed {
      logic                oe;
      logic                from_supply;
      logic [CM_DIV_W-1:0] level;
   } cm_drive_t;

endpackage

// ===== hdl/result_formatter.sv
`timescale 1ns/1ns
module result_formatter #(
   parameter int unsigned RAW_W   = 28,
   parameter int unsigned BIT_DIV = 4
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic signed [RAW_W-1:0]   raw,
   input  wire logic                      raw_valid,
   output logic [cfg_pkg::CODE_W-1:0]     code,
   output logic                           serial,
   output logic                           frame
);
   import cfg_pkg::*;

   logic [CODE_W-1:0] code_r, code_nxt, shift_r, shift_nxt;
   logic [4:0]        left_r, left_nxt;
   logic [7:0]        div_r, div_nxt;
   logic              ser_r, ser_nxt, frame_r, frame_nxt;
   logic [CODE_W-1:0] sat;

   // Clamp to the signed 24-bit extremes
   function automatic logic [CODE_W-1:0] saturate(input logic signed [RAW_W-1:0] v);
      if (v > $signed({{(RAW_W-CODE_W){1'b0}}, CODE_MAX}))
         return CODE_MAX;
      else if (v < $signed({{(RAW_W-CODE_W){1'b1}}, CODE_MIN}))
         return CODE_MIN;
      else
         return v[CODE_W-1:0];
   endfunction

   // Load a new word when idle, then shift it out MSB first
   always_comb begin
      sat       = saturate(raw);
      code_nxt  = code_r;
      shift_nxt = shift_r;
      left_nxt  = left_r;
      div_nxt   = div_r;
      ser_nxt   = ser_r;
      frame_nxt = frame_r;
      if (!frame_r) begin
         if (raw_valid) begin // Samples arriving mid-frame are dropped
            code_nxt  = sat;
            ser_nxt   = sat[CODE_W-1];
            shift_nxt = {sat[CODE_W-2:0], 1'b0};
            left_nxt  = 5'(CODE_W - 1);
            div_nxt   = '0;
            frame_nxt = 1'b1;
         end
      end else if (div_r == 8'(BIT_DIV - 1)) begin
         div_nxt = '0;
         if (left_r == '0) begin
            frame_nxt = 1'b0;
            ser_nxt   = 1'b0;
         end else begin
            ser_nxt   = shift_r[CODE_W-1];
            shift_nxt = {shift_r[CODE_W-2:0], 1'b0};
            left_nxt  = left_r - 5'h01;
         end
      end else begin
         div_nxt = div_r + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_r  <= '0;
         shift_r <= '0;
         left_r  <= '0;
         div_r   <= '0;
         ser_r   <= 1'b0;
         frame_r <= 1'b0;
      end else begin
         code_r  <= code_nxt;
         shift_r <= shift_nxt;
         left_r  <= left_nxt;
         div_r   <= div_nxt;
         ser_r   <= ser_nxt;
         frame_r <= frame_nxt;
      end
   end

   assign code   = code_r;
   assign serial = ser_r;
   assign frame  = frame_r;

endmodule

// ===== hdl/clock_and_bias_config_ctrl.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module clock_and_bias_config_ctrl #(
   parameter int unsigned RAW_W   = 28,
   parameter int unsigned BIT_DIV = 4
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [cfg_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [cfg_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        control_mode_strap,
   input  wire logic                        clock_source_strap,
   input  wire logic                        full_powerdown_pin_n,
   input  wire logic signed [RAW_W-1:0]     raw_result,
   input  wire logic                        raw_valid,
   output cfg_pkg::cm_drive_t               common_mode_output,
   output logic [cfg_pkg::CH_N-1:0]         analog_input_pair_hiz,
   output logic                             reference_input_pin_hiz,
   output logic                             buffered_crystal_clock_out_en,
   output logic                             use_external_clock,
   output logic                             reference_drop_correction_active,
   output logic [2:0]                       reference_current_quarters,
   output logic [cfg_pkg::CODE_W-1:0]       result_code,
   output logic                             result_serial,
   output logic                             result_frame
);
   import cfg_pkg::*;

   // Configuration state
   boot_state_t         boot_r, boot_nxt;
   logic [CNT_W-1:0]    cnt_r, cnt_nxt;
   logic                spi_mode_r, spi_mode_nxt;
   logic                xtal_r, xtal_nxt;
   ctrl_t               ctrl_r, ctrl_nxt;
   logic [CM_DIV_W-1:0] cm_div_r, cm_div_nxt;
   logic [CH_N-1:0]     ch_pd_r, ch_pd_nxt;
   logic                cfg_rst;

   // Bus state
   logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt;
   logic                aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [31:0]         wdata_r, wdata_nxt;
   logic                wlane0_r, wlane0_nxt;
   logic                awready_r, awready_nxt, wready_r, wready_nxt;
   logic                bvalid_r, bvalid_nxt, arready_r, arready_nxt;
   logic [1:0]          bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic                rvalid_r, rvalid_nxt;
   logic [31:0]         rdata_r, rdata_nxt;
   logic                do_write;

   // Pin-facing outputs
   cm_drive_t           cm_r, cm_nxt;
   logic [CH_N-1:0]     ain_hiz_r, ain_hiz_nxt;
   logic                ref_hiz_r, ref_hiz_nxt, xclk_r, xclk_nxt;
   logic                ext_r, ext_nxt, corr_r, corr_nxt;
   logic [2:0]          qtr_r, qtr_nxt;

   logic [CODE_W-1:0]   fmt_code;
   logic                fmt_serial, fmt_frame;

   // Count of powered channels, each one a quarter of reference current
   function automatic logic [2:0] live_channels(input logic [CH_N-1:0] pd);
      logic [2:0] n;
      n = '0;
      for (int i = 0; i < CH_N; i++)
         n = n + {2'b00, ~pd[i]};
      return n;
   endfunction

   // Register-mode divider kept within one to nineteen twentieths
   function automatic logic [CM_DIV_W-1:0] clamp_div(input logic [CM_DIV_W-1:0] d);
      if (d < CM_DIV_MIN)
         return CM_DIV_MIN;
      else if (d > CM_DIV_MAX)
         return CM_DIV_MAX;
      else
         return d;
   endfunction

   // Power-down pin and software reset reset the configuration as well
   assign cfg_rst  = !aresetn || !full_powerdown_pin_n || ctrl_r.soft_reset;
   assign do_write = aw_held_r && w_held_r && !bvalid_r;

   // Strap sampling, start-up on internal oscillator, handover
   always_comb begin
      boot_nxt     = boot_r;
      cnt_nxt      = cnt_r;
      spi_mode_nxt = spi_mode_r;
      xtal_nxt     = xtal_r;
      case (boot_r)
         ST_STRAP: begin
            spi_mode_nxt = control_mode_strap;
            xtal_nxt     = clock_source_strap;
            cnt_nxt      = '0;
            boot_nxt     = ST_OSC;
         end
         ST_OSC: begin
            if (cnt_r == CNT_W'(STARTUP_CYC - 1))
               boot_nxt = ST_RUN;
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         ST_RUN: boot_nxt = ST_RUN;
         default: boot_nxt = ST_STRAP;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (cfg_rst) begin
         boot_r     <= ST_STRAP;
         cnt_r      <= '0;
         spi_mode_r <= 1'b0;
         xtal_r     <= 1'b0;
      end else begin
         boot_r     <= boot_nxt;
         cnt_r      <= cnt_nxt;
         spi_mode_r <= spi_mode_nxt;
         xtal_r     <= xtal_nxt;
      end
   end

   // Register writes; pin mode ignores them so its settings cannot move
   always_comb begin
      ctrl_nxt            = ctrl_r;
      ctrl_nxt.soft_reset = 1'b0;
      cm_div_nxt          = cm_div_r;
      ch_pd_nxt           = ch_pd_r;
      if (do_write && wlane0_r && spi_mode_r && boot_r != ST_STRAP) begin
         case (awaddr_r)
            OFS_CTRL:   ctrl_nxt   = ctrl_t'(wdata_r[CTRL_W-1:0]);
            OFS_CM_DIV: cm_div_nxt = clamp_div(wdata_r[CM_DIV_W-1:0]);
            OFS_CH_PD:  ch_pd_nxt  = wdata_r[CH_N-1:0];
            default:    ctrl_nxt.soft_reset = 1'b0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (cfg_rst) begin
         ctrl_r   <= '0;
         cm_div_r <= CM_DIV_HALF;
         ch_pd_r  <= CH_PD_RST;
      end else begin
         ctrl_r   <= ctrl_nxt;
         cm_div_r <= cm_div_nxt;
         ch_pd_r  <= ch_pd_nxt;
      end
   end

   // Bus slave: address and data in either order, answer once both are held
   always_comb begin
      awaddr_nxt  = awaddr_r;
      aw_held_nxt = aw_held_r;
      wdata_nxt   = wdata_r;
      wlane0_nxt  = wlane0_r;
      w_held_nxt  = w_held_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      arready_nxt = arready_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (s_axi_awvalid && awready_r) begin
         awaddr_nxt  = s_axi_awaddr;
         aw_held_nxt = 1'b1;
      end
      if (s_axi_wvalid && wready_r) begin
         wdata_nxt  = s_axi_wdata;
         wlane0_nxt = s_axi_wstrb[0];
         w_held_nxt = 1'b1;
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         case (awaddr_r)
            OFS_CTRL, OFS_CM_DIV, OFS_CH_PD: bresp_nxt = RESP_OKAY;
            default:                          bresp_nxt = RESP_SLVERR;
         endcase
      end
      if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (s_axi_arvalid && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rresp_nxt   = RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL:   rdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
            OFS_CM_DIV: rdata_nxt = {{(32-CM_DIV_W){1'b0}}, cm_div_r};
            OFS_CH_PD:  rdata_nxt = {{(32-CH_N){1'b0}}, ch_pd_r};
            OFS_STATUS: begin
               rdata_nxt = '0;
               rdata_nxt[ST_SPI_POS]  = spi_mode_r;
               rdata_nxt[ST_XTAL_POS] = xtal_r;
               rdata_nxt[ST_EXT_POS]  = ext_r;
               rdata_nxt[ST_CORR_POS] = corr_r;
               rdata_nxt[ST_QTR_POS +: 3] = qtr_r;
            end
            OFS_CODE:   rdata_nxt = {{(32-CODE_W){1'b0}}, fmt_code};
            default: begin
               rdata_nxt = '0;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
      // Readies drop while a word is held so nothing is overwritten
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt  = !w_held_nxt && !bvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_r  <= '0;
         aw_held_r <= 1'b0;
         wdata_r   <= '0;
         wlane0_r  <= 1'b0;
         w_held_r  <= 1'b0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else begin
         awaddr_r  <= awaddr_nxt;
         aw_held_r <= aw_held_nxt;
         wdata_r   <= wdata_nxt;
         wlane0_r  <= wlane0_nxt;
         w_held_r  <= w_held_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // Pin-facing outputs from mode, straps and registers
   always_comb begin
      cm_nxt      = '0;
      ain_hiz_nxt = '1;
      ref_hiz_nxt = 1'b1;
      xclk_nxt    = 1'b0;
      corr_nxt    = 1'b0;
      qtr_nxt     = '0;
      ext_nxt     = boot_r == ST_RUN;
      if (boot_r == ST_RUN) begin
         if (!spi_mode_r) begin
            cm_nxt.oe    = 1'b1;
            cm_nxt.level = CM_DIV_HALF;
            xclk_nxt     = xtal_r;
            ain_hiz_nxt  = '0;
            ref_hiz_nxt  = 1'b0;
            qtr_nxt      = 3'(CH_N);
         end else begin
            cm_nxt.oe          = !ctrl_r.cm_buf_pwrdn;
            cm_nxt.from_supply = ctrl_r.cm_src_sel;
            cm_nxt.level       = cm_div_r;
            xclk_nxt           = ctrl_r.clk_out_en && xtal_r;
            ain_hiz_nxt        = ctrl_r.sleep_en ? '1 : ch_pd_r;
            ref_hiz_nxt        = ctrl_r.sleep_en;
            qtr_nxt            = ctrl_r.sleep_en ? 3'h0 : live_channels(ch_pd_r);
            corr_nxt           = ctrl_r.ref_corr_en && !ctrl_r.sleep_en;
         end
      end
   end

   // Power-down pin forces every analog pin undriven at the next clock edge
   always_ff @(posedge aclk) begin
      if (cfg_rst) begin
         cm_r      <= '0;
         ain_hiz_r <= '1;
         ref_hiz_r <= 1'b1;
         xclk_r    <= 1'b0;
         ext_r     <= 1'b0;
         corr_r    <= 1'b0;
         qtr_r     <= '0;
      end else begin
         cm_r      <= cm_nxt;
         ain_hiz_r <= ain_hiz_nxt;
         ref_hiz_r <= ref_hiz_nxt;
         xclk_r    <= xclk_nxt;
         ext_r     <= ext_nxt;
         corr_r    <= corr_nxt;
         qtr_r     <= qtr_nxt;
      end
   end

   // Results are only formatted while the converter runs
   result_formatter #(
      .RAW_W   (RAW_W),
      .BIT_DIV (BIT_DIV)
   ) u_fmt (
      .aclk      (aclk),
      .aresetn   (!cfg_rst),
      .raw       (raw_result),
      .raw_valid (raw_valid && ext_r && !ref_hiz_r),
      .code      (fmt_code),
      .serial    (fmt_serial),
      .frame     (fmt_frame)
   );

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   assign common_mode_output               = cm_r;
   assign analog_input_pair_hiz            = ain_hiz_r;
   assign reference_input_pin_hiz          = ref_hiz_r;
   assign buffered_crystal_clock_out_en    = xclk_r;
   assign use_external_clock               = ext_r;
   assign reference_drop_correction_active = corr_r;
   assign reference_current_quarters       = qtr_r;
   assign result_code                      = fmt_code;
   assign result_serial                    = fmt_serial;
   assign result_frame                     = fmt_frame;

endmodule

// ===== verification/board_straps.sv
`timescale 1ns/1ns
// Board straps as the host side ties them; levels move while the part is held off and, once, while it runs
module board_straps (
   input  wire logic reg_mode,
   input  wire logic xtal_fit,
   output logic      control_mode_strap,
   output logic      clock_source_strap
);
   // Plain wiring: a strap moved while running must be ignored by the part
   assign control_mode_strap = reg_mode;
   assign clock_source_strap = xtal_fit;
endmodule

// ===== verification/cbc_chk.sv
`timescale 1ns/1ns
module cbc_chk #(
   parameter int unsigned BIT_DIV = 4
) (
   input wire logic                     aclk,
   input wire logic                     aresetn,
   input wire logic                     s_axi_awvalid,
   input wire logic                     s_axi_awready,
   input wire logic                     s_axi_wvalid,
   input wire logic                     s_axi_wready,
   input wire logic                     s_axi_bvalid,
   input wire logic                     s_axi_bready,
   input wire logic                     s_axi_arvalid,
   input wire logic                     s_axi_arready,
   input wire logic                     s_axi_rvalid,
   input wire logic                     full_powerdown_pin_n,
   input wire cfg_pkg::cm_drive_t       common_mode_output,
   input wire logic [cfg_pkg::CH_N-1:0] analog_input_pair_hiz,
   input wire logic                     reference_input_pin_hiz,
   input wire logic                     buffered_crystal_clock_out_en,
   input wire logic                     use_external_clock,
   input wire logic                     reference_drop_correction_active,
   input wire logic [2:0]               reference_current_quarters,
   input wire logic [23:0]              result_code,
   input wire logic                     result_serial,
   input wire logic                     result_frame
);
   import cfg_pkg::*;
   localparam int FRAME_LAST = 24 * BIT_DIV - 1;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Both halves of a write taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_waiting;
      s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after the write");
   a_resp_held: assert property (s_axi_bvalid |->
      resp_waiting ##1 (s_axi_bvalid || $past(s_axi_bready)))
      else $error("write response dropped before bready");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after the address");
   a_pdn_hiz: assert property (!full_powerdown_pin_n |=> reference_input_pin_hiz && &analog_input_pair_hiz)
      else $error("inputs driven during power-down");
   a_pdn_quiet: assert property (!full_powerdown_pin_n |=> common_mode_output == '0 && !use_external_clock && !buffered_crystal_clock_out_en && !reference_drop_correction_active)
      else $error("outputs not at defaults during power-down");
   a_boot_osc: assert property ($rose(aresetn) |-> !use_external_clock [*8])
      else $error("external clock taken before start-up");
   a_quarter_max: assert property (reference_current_quarters <= 3'h4)
      else $error("quarter count above four");
   a_level_range: assert property (common_mode_output.oe && !common_mode_output.from_supply |-> common_mode_output.level inside {[CM_DIV_MIN:CM_DIV_MAX]})
      else $error("common-mode level out of range");
   a_corr_ref: assert property (reference_drop_correction_active |-> !reference_input_pin_hiz)
      else $error("correction active with reference released");
   a_frame_msb: assert property ($rose(result_frame) |-> result_serial == result_code[23])
      else $error("word does not start with its top bit");
   a_frame_len: assert property ($rose(result_frame) |-> ##FRAME_LAST result_frame ##1 !result_frame)
      else $error("frame length wrong");
endmodule
bind clock_and_bias_config_ctrl cbc_chk #(.BIT_DIV(BIT_DIV)) u_cbc_chk (.*);

// ===== verification/test_clock_and_bias_config_ctrl.sv
`timescale 1ns/1ns
module test_clock_and_bias_config_ctrl;
   import cfg_pkg::*;
   localparam int unsigned BIT_DIV = 4;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0]        s_axi_wstrb = 4'hf, analog_input_pair_hiz, p;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, raw_valid = 1'b0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
   logic              full_powerdown_pin_n = 1'b1, reg_mode = 1'b1, xtal_fit = 1'b1;
   logic              control_mode_strap, clock_source_strap, reference_input_pin_hiz;
   logic              buffered_crystal_clock_out_en, use_external_clock;
   logic              reference_drop_correction_active, result_serial, result_frame;
   logic signed [27:0] raw_result = 28'h0;
   logic [2:0]        reference_current_quarters;
   logic [23:0]       result_code;
   logic [4:0]        d;
   cm_drive_t         common_mode_output;
   int                error_cnt = 0, total_checks = 0, cyc = 0;
   logic signed [27:0] raws [7] = '{28'sh0, 28'sh1, -28'sh1, 28'sh07fffff, 28'sh0800000,
                                    -28'sh0800000, 28'sh8000000};
   board_straps u_board_straps (.*);
   clock_and_bias_config_ctrl #(.BIT_DIV(BIT_DIV)) u_clock_and_bias_config_ctrl (.*);
   // Free-running 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // A hung handshake must not stall the run forever
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write: both channels offered together, each dropped once taken, bready held till bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      // Registered outputs settle a cycle after the write lands
      repeat (2) @(posedge aclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            rv = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic wait_run;
      for (int i = 0; i < 400 && use_external_clock !== 1'b1; i++) begin
         @(posedge aclk);
      end
      repeat (2) @(posedge aclk);
      #1;
   endtask
   task automatic boot(input logic m, input logic c);
      @(posedge aclk);
      reg_mode <= m;
      xtal_fit <= c;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      wait_run();
   endtask
   function automatic logic [23:0] clampv(input logic signed [27:0] v);
      if (v > 28'sh07fffff) return CODE_MAX;
      if (v < -28'sh0800000) return CODE_MIN;
      return v[23:0];
   endfunction
   // One word through the formatter, each bit looked at mid-slot
   task automatic fmt(input logic signed [27:0] v);
      logic [23:0] e;
      e = clampv(v);
      @(posedge aclk);
      raw_result <= v;
      raw_valid <= 1'b1;
      @(posedge aclk);
      raw_valid <= 1'b0;
      #1;
      chk(result_code, e);
      for (int i = 23; i >= 0; i--) begin
         #(BIT_DIV * 5);
         chk(result_serial, e[i]);
         #(BIT_DIV * 5);
      end
      #1;
      chk(result_frame, 0);
   endtask
   initial begin
      rv = $urandom(42081);
      boot(1'b1, 1'b1);
      chk(common_mode_output, 7'h4a);
      chk(buffered_crystal_clock_out_en, 0);
      chk(reference_drop_correction_active, 0);
      rd(OFS_STATUS);
      chk(rv, 32'h47);
      wr(OFS_CTRL, 32'h03);
      chk(buffered_crystal_clock_out_en, 1);
      chk(reference_drop_correction_active, 1);
      for (int i = 0; i < 6; i++) begin
         p = (i == 0) ? 4'hf : 4'($urandom);
         wr(OFS_CH_PD, {28'h0, p});
         chk(analog_input_pair_hiz, p);
         chk(reference_current_quarters, 4 - $countones(p));
      end
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
         wr(OFS_CM_DIV, {27'h0, d});
         chk(common_mode_output.level, (d == 0) ? 1 : (d > 19) ? 19 : d);
      end
      wr(OFS_CH_PD, 32'h0);
      foreach (raws[i]) fmt(raws[i]);
      rd(OFS_CODE);
      chk(rv, 32'h800000);
      fmt(28'($urandom));
      fmt(-28'sh0 - 28'($urandom % 1000));
      wr(OFS_CTRL, 32'h08);
      chk(common_mode_output.from_supply, 1);
      chk(buffered_crystal_clock_out_en, 0);
      wr(OFS_CTRL, 32'h04);
      chk(common_mode_output.oe, 0);
      wr(OFS_CTRL, 32'h11);
      chk({reference_input_pin_hiz, analog_input_pair_hiz}, 5'h1f);
      chk({reference_drop_correction_active, reference_current_quarters}, 0);
      wr(8'h14, 32'h1);
      chk(rs, RESP_SLVERR);
      rd(8'h14);
      chk({rs, rv}, {RESP_SLVERR, 32'h0});
      wr(OFS_CTRL, 32'h20);
      wait_run();
      chk({reference_input_pin_hiz, analog_input_pair_hiz}, 5'h00);
      // Power-down pin acts as a full reset of the configuration
      @(posedge aclk);
      full_powerdown_pin_n <= 1'b0;
      repeat (3) @(posedge aclk);
      #1;
      chk({reference_input_pin_hiz, analog_input_pair_hiz}, 5'h1f);
      @(posedge aclk);
      full_powerdown_pin_n <= 1'b1;
      wait_run();
      rd(OFS_CTRL);
      chk(rv, 32'h0);
      chk(common_mode_output, 7'h4a);
      boot(1'b0, 1'b0);
      chk(common_mode_output, 7'h4a);
      chk(buffered_crystal_clock_out_en, 0);
      wr(OFS_CTRL, 32'h01);
      chk({rs, reference_drop_correction_active}, {RESP_OKAY, 1'b0});
      wr(OFS_CM_DIV, 32'h03);
      chk(common_mode_output, 7'h4a);
      @(posedge aclk);
      reg_mode <= 1'b1;
      wr(OFS_CTRL, 32'h01);
      chk(reference_drop_correction_active, 0);
      boot(1'b0, 1'b1);
      chk(buffered_crystal_clock_out_en, 1);
      rd(OFS_STATUS);
      chk(rv, 32'h46);
      tally_and_finish();
   end
endmodule
